/* design/mss_pkg.sv */
// package: register map, field layout, timing constants and types
package mss_pkg;
  // ********************************************************************
  // register offsets (byte addresses)
  // ********************************************************************
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_TSET     = 8'h04;
  localparam logic [7:0] OFF_TSAFE    = 8'h08;
  localparam logic [7:0] OFF_ISTART   = 8'h0c;
  localparam logic [7:0] OFF_INOLOAD  = 8'h10;
  localparam logic [7:0] OFF_IDONE    = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_ACCUM    = 8'h24;
  localparam logic [7:0] OFF_ELAPSED  = 8'h28;
  localparam logic [7:0] OFF_TCOLD    = 8'h2c;
  localparam logic [7:0] OFF_THOT     = 8'h30;
  localparam logic [7:0] OFF_INOM_ST  = 8'h34;

  // ********************************************************************
  // control fields
  // ********************************************************************
  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_I2T_MODE = 1;
  localparam int CTRL_AUTO_SRC = 2;
  localparam int CTRL_SPEED_EN = 3;
  localparam int CTRL_STALL_EN = 4;
  localparam int CTRL_TRIP_CLR = 5;

  // interrupt bits
  localparam int IRQ_START = 0;
  localparam int IRQ_DONE  = 1;
  localparam int IRQ_TRIP  = 2;
  localparam int IRQ_STALL = 3;

  // ********************************************************************
  // reset values and timing
  // ********************************************************************
  localparam logic [31:0] RST_CTRL    = 32'h0000_0001;
  localparam logic [31:0] RST_TSET    = 32'h0000_0064;
  localparam logic [31:0] RST_TSAFE   = 32'h0000_00c8;
  localparam logic [15:0] RST_ISTART  = 16'h0096;
  localparam logic [15:0] RST_INOLOAD = 16'h000a;
  localparam logic [15:0] RST_IDONE   = 16'h0078;
  localparam logic [15:0] RST_INOM_ST = 16'h0258;
  localparam int CLK_MHZ          = 100;
  localparam int DETECT_WINDOW_MS = 10;
  localparam int DETECT_WINDOW_CYC = DETECT_WINDOW_MS * 1000 * CLK_MHZ;

  // ********************************************************************
  // types
  // ********************************************************************
  typedef enum logic [1:0] {
    ST_STOPPED  = 2'b00,
    ST_STARTING = 2'b01,
    ST_RUNNING  = 2'b10,
    ST_STALLED  = 2'b11
  } mss_state_e;

  typedef struct packed {
    logic [15:0] l1;
    logic [15:0] l2;
    logic [15:0] l3;
  } mss_phase_s;

  typedef struct packed {
    logic        enable;
    logic        i2t_mode;
    logic        auto_src;
    logic        speed_en;
    logic        stall_en;
  } mss_ctrl_s;
endpackage : mss_pkg

/* design/mss_max_phase.sv */
// largest of the three phase-current magnitudes, registered
`timescale 1ns/1ps
module mss_max_phase (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               smp_en,
  input  wire mss_pkg::mss_phase_s phase,
  output logic [15:0]             imax
);
  logic [15:0] ab;

  assign ab = (phase.l1 > phase.l2) ? phase.l1 : phase.l2;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      imax <= 16'h0000;
    end else if (smp_en) begin
      imax <= (ab > phase.l3) ? ab : phase.l3;
    end
  end
endmodule : mss_max_phase

/* design/mss_supervisor.sv */
// motor start and locked-rotor supervisor with ahb-lite registers
// Notes on behaviour
// - two modes: definite locked-rotor time or current-squared-time budget
// - i2t mode allows longer starts when start current is lower
// - allowed time from manual setting or hot/cold stall times by thermal
// - in i2t mode accumulate current squared and compare with the limit
// - start longer than allowed without speed switch asserts trip
// - active speed switch withholds trip past set start time
// - trip anyway once start exceeds safe stall time
// - stall supervision reuses start time and i2t settings
// - stall monitoring trips when allowed time exceeded during stall
// - start counts only if both limits crossed within ten milliseconds
`timescale 1ns/1ps
module mss_supervisor (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               smp_en,
  input  wire mss_pkg::mss_phase_s phase,
  input  wire logic               speed_sw,
  input  wire logic               thermal_valid,
  input  wire logic [15:0]        thermal_level,
  output logic                    trip,
  output logic                    start_active,
  output logic                    irq
);
  // ********************************************************************
  // registers
  // ********************************************************************
  logic [31:0]         ctrl_r;
  logic [31:0]         tset_r;
  logic [31:0]         tsafe_r;
  logic [31:0]         tcold_r;
  logic [31:0]         thot_r;
  logic [15:0]         istart_r;
  logic [15:0]         inoload_r;
  logic [15:0]         idone_r;
  logic [15:0]         inom_st_r;
  logic [3:0]          irq_stat_r;
  logic [3:0]          irq_mask_r;
  logic                wr_pend_r;
  logic [7:0]          addr_r;
  logic [31:0]         elapsed_r;
  logic [63:0]         accum_r;
  logic                trip_r;
  logic                start_r;
  logic                stall_r;
  logic [31:0]         win_cnt_r;
  logic                armed_r;
  mss_pkg::mss_state_e state_r;
  mss_pkg::mss_ctrl_s  cfg;
  logic [15:0]         imax;
  logic                addr_phase;
  logic                trip_clr;
  logic [31:0]         t_allow;
  logic [63:0]         i2t_limit;
  logic [31:0]         i2_now;
  logic                over_time;
  logic                over_safe;
  logic                over_i2t;
  logic                do_trip;
  logic                ev_start;
  logic                ev_done;
  logic                ev_stall;
  logic [3:0]          ev_vec;

  assign cfg.enable   = ctrl_r[mss_pkg::CTRL_ENABLE];
  assign cfg.i2t_mode = ctrl_r[mss_pkg::CTRL_I2T_MODE];
  assign cfg.auto_src = ctrl_r[mss_pkg::CTRL_AUTO_SRC];
  assign cfg.speed_en = ctrl_r[mss_pkg::CTRL_SPEED_EN];
  assign cfg.stall_en = ctrl_r[mss_pkg::CTRL_STALL_EN];

  mss_max_phase u_max (
    .hclk    (hclk),
    .hresetn (hresetn),
    .smp_en  (smp_en),
    .phase   (phase),
    .imax    (imax)
  );

  // ********************************************************************
  // ahb-lite slave, zero wait states
  // ********************************************************************
  assign addr_phase = hsel & hready & htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign trip_clr   = wr_pend_r && addr_r == mss_pkg::OFF_CTRL
                      && hwdata[mss_pkg::CTRL_TRIP_CLR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      addr_r    <= 8'h00;
    end else begin
      wr_pend_r <= addr_phase & hwrite;
      if (addr_phase) begin
        addr_r <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r     <= mss_pkg::RST_CTRL;
      tset_r     <= mss_pkg::RST_TSET;
      tsafe_r    <= mss_pkg::RST_TSAFE;
      tcold_r    <= mss_pkg::RST_TSAFE;
      thot_r     <= mss_pkg::RST_TSET;
      istart_r   <= mss_pkg::RST_ISTART;
      inoload_r  <= mss_pkg::RST_INOLOAD;
      idone_r    <= mss_pkg::RST_IDONE;
      inom_st_r  <= mss_pkg::RST_INOM_ST;
      irq_mask_r <= 4'h0;
    end else if (wr_pend_r) begin
      unique case (addr_r)
        mss_pkg::OFF_CTRL:     ctrl_r     <= {27'h0, hwdata[4:0]};
        mss_pkg::OFF_TSET:     tset_r     <= hwdata;
        mss_pkg::OFF_TSAFE:    tsafe_r    <= hwdata;
        mss_pkg::OFF_TCOLD:    tcold_r    <= hwdata;
        mss_pkg::OFF_THOT:     thot_r     <= hwdata;
        mss_pkg::OFF_ISTART:   istart_r   <= hwdata[15:0];
        mss_pkg::OFF_INOLOAD:  inoload_r  <= hwdata[15:0];
        mss_pkg::OFF_IDONE:    idone_r    <= hwdata[15:0];
        mss_pkg::OFF_INOM_ST:  inom_st_r  <= hwdata[15:0];
        mss_pkg::OFF_IRQ_MASK: irq_mask_r <= hwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        mss_pkg::OFF_CTRL:     hrdata <= ctrl_r;
        mss_pkg::OFF_TSET:     hrdata <= tset_r;
        mss_pkg::OFF_TSAFE:    hrdata <= tsafe_r;
        mss_pkg::OFF_TCOLD:    hrdata <= tcold_r;
        mss_pkg::OFF_THOT:     hrdata <= thot_r;
        mss_pkg::OFF_ISTART:   hrdata <= {16'h0, istart_r};
        mss_pkg::OFF_INOLOAD:  hrdata <= {16'h0, inoload_r};
        mss_pkg::OFF_IDONE:    hrdata <= {16'h0, idone_r};
        mss_pkg::OFF_INOM_ST:  hrdata <= {16'h0, inom_st_r};
        mss_pkg::OFF_STATUS:   hrdata <= {26'h0, state_r, 1'b0,
                                          stall_r, start_r, trip_r};
        mss_pkg::OFF_IRQ_STAT: hrdata <= {28'h0, irq_stat_r};
        mss_pkg::OFF_IRQ_MASK: hrdata <= {28'h0, irq_mask_r};
        mss_pkg::OFF_ACCUM:    hrdata <= accum_r[47:16];
        mss_pkg::OFF_ELAPSED:  hrdata <= elapsed_r;
        default:               hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ********************************************************************
  // allowed time and i2t budget
  // ********************************************************************
  always_comb begin
    // thermal level 0 = cold, ffff = hot; interpolate stall time
    if (cfg.auto_src && thermal_valid) begin
      t_allow = tcold_r - 32'((64'(tcold_r - thot_r)
                * 64'(thermal_level)) >> 16);
    end else begin
      t_allow = tset_r;
    end
  end

  // budget = nominal start current squared times allowed time
  assign i2t_limit = 64'(32'(inom_st_r) * 32'(inom_st_r)) * 64'(t_allow);
  assign i2_now    = 32'(imax) * 32'(imax);

  assign over_time = elapsed_r >= t_allow;
  assign over_safe = elapsed_r >= tsafe_r;
  assign over_i2t  = accum_r >= i2t_limit;

  always_comb begin
    do_trip = 1'b0;
    if (start_r || stall_r) begin
      if (cfg.i2t_mode) begin
        do_trip = over_i2t;
      end else begin
        do_trip = over_time;
      end
      if (cfg.speed_en && speed_sw) begin
        do_trip = over_safe;
      end
    end
  end

  // ********************************************************************
  // start detection window
  // ********************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_r   <= 1'b0;
      win_cnt_r <= 32'h0000_0000;
    end else if (smp_en && imax <= inoload_r) begin
      armed_r   <= 1'b0;
      win_cnt_r <= 32'h0000_0000;
    end else if (smp_en && !armed_r) begin
      armed_r   <= 1'b1;
      win_cnt_r <= 32'h0000_0000;
    end else if (armed_r && win_cnt_r < 32'(mss_pkg::DETECT_WINDOW_CYC)) begin
      // window is counted in clock cycles, not in sample strobes
      win_cnt_r <= win_cnt_r + 32'h0000_0001;
    end
  end

  // both limits crossed within the window from leaving no-load
  assign ev_start = smp_en && state_r == mss_pkg::ST_STOPPED && !trip_r
                    && cfg.enable && imax > istart_r && imax > inoload_r
                    && (!armed_r
                        || win_cnt_r < 32'(mss_pkg::DETECT_WINDOW_CYC));
  assign ev_done  = smp_en && state_r == mss_pkg::ST_STARTING
                    && imax < idone_r && !do_trip;
  assign ev_stall = smp_en && state_r == mss_pkg::ST_RUNNING
                    && cfg.stall_en && imax > istart_r;

  // ********************************************************************
  // supervision state, accumulator and trip latch
  // ********************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= mss_pkg::ST_STOPPED;
    end else if (do_trip || !cfg.enable) begin
      state_r <= mss_pkg::ST_STOPPED;
    end else if (smp_en) begin
      unique case (state_r)
        mss_pkg::ST_STOPPED: begin
          if (ev_start) begin
            state_r <= mss_pkg::ST_STARTING;
          end
        end
        mss_pkg::ST_STARTING: begin
          if (ev_done) begin
            state_r <= mss_pkg::ST_RUNNING;
          end
        end
        mss_pkg::ST_RUNNING: begin
          if (ev_stall) begin
            state_r <= mss_pkg::ST_STALLED;
          end else if (imax <= inoload_r) begin
            state_r <= mss_pkg::ST_STOPPED;
          end
        end
        mss_pkg::ST_STALLED: begin
          if (imax < idone_r) begin
            state_r <= mss_pkg::ST_RUNNING;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      elapsed_r <= 32'h0000_0000;
      accum_r   <= 64'h0;
    end else if (ev_start || ev_stall || !(start_r || stall_r)) begin
      elapsed_r <= 32'h0000_0000;
      accum_r   <= 64'h0;
    end else if (smp_en) begin
      elapsed_r <= elapsed_r + 32'h0000_0001;
      accum_r   <= accum_r + 64'(i2_now);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_r <= 1'b0;
    end else if (do_trip) begin
      trip_r <= 1'b1;
    end else if (trip_clr) begin
      trip_r <= 1'b0;
    end
  end

  assign start_r = state_r == mss_pkg::ST_STARTING;
  assign stall_r = state_r == mss_pkg::ST_STALLED;
  assign trip         = trip_r;
  assign start_active = start_r;

  // ********************************************************************
  // interrupts: sticky, write one to clear, set wins
  // ********************************************************************
  assign ev_vec = {ev_stall, do_trip, ev_done, ev_start};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_r <= 4'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_pend_r
                    && addr_r == mss_pkg::OFF_IRQ_STAT) ? hwdata[3:0]
                    : 4'h0)) | ev_vec;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);
endmodule : mss_supervisor

/* tb/mss_front_end.sv */
// partner model: phase current front end, sample strobe, breaker
`timescale 1ns/1ps
module mss_front_end (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic [15:0]    level,
  input  wire logic           rotating,
  input  wire logic           trip,
  output logic                smp_en,
  output mss_pkg::mss_phase_s phase,
  output logic                speed_sw
);
  logic [1:0]  div_r;
  logic [15:0] cur;
  // ****************
  // strobe every fourth cycle
  // ****************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_r  <= 2'h0;
      smp_en <= 1'b0;
    end else begin
      div_r  <= div_r + 2'h1;
      smp_en <= div_r == 2'h3;
    end
  end
  // open breaker kills all phases and stops the shaft
  assign cur      = trip ? 16'h0000 : level;
  assign phase    = {cur >> 1, cur, cur >> 2};
  assign speed_sw = rotating && cur != 16'h0000;
endmodule : mss_front_end

/* tb/mss_supervisor_chk.sv */
// checker: bus, trip and start relations at the supervisor ports
`timescale 1ns/1ps
module mss_chk (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic [31:0]         hrdata,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic                smp_en,
  input wire mss_pkg::mss_phase_s phase,
  input wire logic                trip,
  input wire logic                start_active,
  input wire logic                irq
);
  logic wr_r;
  logic clr_q;
  logic nz_r;
  logic clr_now;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ****************
  // helper state
  // ****************
  // ctrl write in its data phase carrying the trip clear bit
  assign clr_now = wr_r && hwdata[mss_pkg::CTRL_TRIP_CLR];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r  <= 1'b0;
      clr_q <= 1'b0;
      nz_r  <= 1'b0;
    end else begin
      wr_r  <= hsel && hready && htrans[1] && hwrite
               && haddr[7:0] == mss_pkg::OFF_CTRL;
      clr_q <= clr_now;
      nz_r  <= |phase;
    end
  end
  // ****************
  // properties
  // ****************
  property p_bus_ready; hreadyout; endproperty
  a_bus_ready: assert property (p_bus_ready)
    else $error("wait state inserted");
  property p_bus_okay; !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("error response");
  property p_rdata_hold;
    !(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_trip_hold; trip && !clr_now && !clr_q |=> trip; endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip dropped without clear");
  property p_trip_ends_start; $rose(trip) |-> ##[0:10] !start_active;
  endproperty
  a_trip_ends_start: assert property (p_trip_ends_start)
    else $error("start flag outlived trip");
  property p_start_on_smp; $rose(start_active) |-> $past(smp_en);
  endproperty
  a_start_on_smp: assert property (p_start_on_smp)
    else $error("start flag rose off the sample strobe");
  property p_start_cause; $rose(start_active) |-> nz_r; endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("start flag without current");
  property p_trip_cause; $rose(trip) |-> nz_r; endproperty
  a_trip_cause: assert property (p_trip_cause)
    else $error("trip without current");
  c_start: cover property ($rose(start_active));
  c_trip: cover property ($rose(trip));
  c_irq: cover property ($rose(irq));
endmodule : mss_chk
bind mss_supervisor mss_chk i_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .smp_en, .phase, .trip, .start_active, .irq
);

/* tb/tb_motor_start_stall_supervisor.sv */
// testbench: supervisor scenarios over ahb-lite with a front end model
`timescale 1ns/1ps
module tb_motor_start_stall_supervisor;
  logic                hclk, hresetn, hsel, hwrite, hready, hreadyout;
  logic                hresp, smp_en, speed_sw, rotating, thermal_valid;
  logic                trip, start_active, irq, a;
  logic [1:0]          htrans;
  logic [2:0]          hsize;
  logic [31:0]         haddr, hwdata, hrdata, rd;
  logic [15:0]         level, thermal_level;
  mss_pkg::mss_phase_s phase;
  int                  bad_count, check_count, n_a, n_b;
  assign hready = hreadyout;
  mss_supervisor i_dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .smp_en, .phase, .speed_sw,
    .thermal_valid, .thermal_level, .trip, .start_active, .irq
  );
  mss_front_end i_fe (
    .hclk, .hresetn, .level, .rotating, .trip, .smp_en, .phase, .speed_sw
  );
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic chk(string w, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", w, exp, seen);
    end
  endtask : chk
  task automatic rng(string w, int n, int lo, int hi);
    chk(w, 32'(n >= lo && n <= hi), 32'h1);
  endtask : rng
  task automatic bus_wait();
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (k == 20) begin
      chk("hreadyout", hreadyout, 1'b1);
      print_verdict();
    end
  endtask : bus_wait
  task automatic bus(logic w, logic [7:0] ad, logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, ad};
    htrans <= 2'b10;
    hwrite <= w;
    bus_wait();
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    bus_wait();
    rd = hrdata;
  endtask : bus
  task automatic go(logic [31:0] ctrl, logic [15:0] cur);
    bus(1'b1, mss_pkg::OFF_CTRL, ctrl);
    level <= cur;
  endtask : go
  // counts sample strobes from current onset to trip
  task automatic count(output int n);
    int k;
    n = 0;
    for (k = 0; k < 2000 && trip !== 1'b1; k++) begin
      @(posedge hclk);
      n += int'(smp_en === 1'b1);
    end
    if (trip !== 1'b1) begin
      chk("trip timeout", trip, 1'b1);
      print_verdict();
    end
  endtask : count
  task automatic wait_start(logic v);
    int k;
    for (k = 0; k < 200; k++) begin
      @(posedge hclk);
      if (start_active === v) break;
    end
    chk("start flag", start_active, v);
    if (start_active !== v) print_verdict();
  endtask : wait_start
  task automatic rearm(logic [31:0] ctrl);
    int k;
    level <= 16'h0000;
    bus(1'b1, mss_pkg::OFF_CTRL, ctrl | 32'h20);
    bus(1'b1, mss_pkg::OFF_IRQ_STAT, 32'hf);
    for (k = 0; k < 20; k++) begin
      bus(1'b0, mss_pkg::OFF_STATUS, 32'h0);
      if (rd[5:4] === mss_pkg::ST_STOPPED) break;
    end
    chk("stopped", rd[5:4], mss_pkg::ST_STOPPED);
    if (rd[5:4] !== mss_pkg::ST_STOPPED) print_verdict();
    chk("trip clear", trip, 1'b0);
    chk("irq clear", irq, 1'b0);
  endtask : rearm
  // ****************
  // scenarios
  // ****************
  task automatic t_regs();
    logic [7:0]  ad [7] = '{mss_pkg::OFF_CTRL, mss_pkg::OFF_TSET,
      mss_pkg::OFF_TSAFE, mss_pkg::OFF_ISTART, mss_pkg::OFF_IDONE,
      mss_pkg::OFF_INOM_ST, 8'h40};
    logic [31:0] ex [7] = '{mss_pkg::RST_CTRL, mss_pkg::RST_TSET,
      mss_pkg::RST_TSAFE, 32'(mss_pkg::RST_ISTART),
      32'(mss_pkg::RST_IDONE), 32'(mss_pkg::RST_INOM_ST), 32'h0};
    bus(1'b1, 8'h40, 32'hffff_ffff);
    foreach (ad[i]) begin
      bus(1'b0, ad[i], 32'h0);
      chk("reset value", rd, ex[i]);
    end
    bus(1'b1, mss_pkg::OFF_ISTART, 32'h40);
    bus(1'b0, mss_pkg::OFF_ISTART, 32'h0);
    chk("istart rw", rd, 32'h40);
  endtask : t_regs
  task automatic t_definite();
    bus(1'b1, mss_pkg::OFF_TSET, 32'h6);
    go(32'h1, 16'h0200);
    count(n_a);
    rng("definite time", n_a, 6, 10);
    repeat (20) @(posedge hclk);
    chk("trip held", trip, 1'b1);
    bus(1'b0, mss_pkg::OFF_IRQ_STAT, 32'h0);
    chk("events", rd[3:0], 4'b0101);
    bus(1'b1, mss_pkg::OFF_IRQ_MASK, 32'h0);
    @(posedge hclk);
    a = irq;
    bus(1'b1, mss_pkg::OFF_IRQ_MASK, 32'hf);
    @(posedge hclk);
    chk("irq masked", a, 1'b0);
    chk("irq unmasked", irq, 1'b1);
    rearm(32'h1);
  endtask : t_definite
  task automatic t_speed();
    bus(1'b1, mss_pkg::OFF_TSAFE, 32'h14);
    go(32'h9, 16'h0200);
    count(n_a);
    rng("no rotation", n_a, 6, 10);
    rearm(32'h9);
    rotating <= 1'b1;
    go(32'h9, 16'h0200);
    count(n_a);
    rng("rotation", n_a, 20, 24);
    rearm(32'h9);
    rotating <= 1'b0;
  endtask : t_speed
  task automatic t_i2t();
    bus(1'b1, mss_pkg::OFF_TSET, 32'h4);
    bus(1'b1, mss_pkg::OFF_TSAFE, 32'hc8);
    bus(1'b1, mss_pkg::OFF_INOM_ST, 32'h100);
    go(32'h3, 16'h0100);
    count(n_a);
    rearm(32'h3);
    go(32'h3, 16'h0080);
    count(n_b);
    rearm(32'h3);
    rng("i2t nominal", n_a, 4, 8);
    rng("i2t low current", n_b, 16, 20);
  endtask : t_i2t
  task automatic t_auto();
    bus(1'b1, mss_pkg::OFF_TCOLD, 32'h10);
    bus(1'b1, mss_pkg::OFF_THOT, 32'h6);
    thermal_valid <= 1'b1;
    go(32'h5, 16'h0200);
    count(n_a);
    rearm(32'h5);
    thermal_level <= 16'hffff;
    go(32'h5, 16'h0200);
    count(n_b);
    rearm(32'h5);
    rng("cold time", n_a, 16, 20);
    rng("hot time", n_b, 6, 10);
  endtask : t_auto
  task automatic t_stall();
    bus(1'b1, mss_pkg::OFF_TSET, 32'h6);
    go(32'h11, 16'h0200);
    wait_start(1'b1);
    level <= 16'h0030;
    wait_start(1'b0);
    chk("running", trip, 1'b0);
    level <= 16'h0200;
    count(n_a);
    rng("stall time", n_a, 6, 10);
    bus(1'b0, mss_pkg::OFF_IRQ_STAT, 32'h0);
    chk("stall event", rd[mss_pkg::IRQ_STALL], 1'b1);
    chk("done event", rd[mss_pkg::IRQ_DONE], 1'b1);
    rearm(32'h11);
  endtask : t_stall
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    level = 16'h0000;
    rotating = 1'b0;
    thermal_valid = 1'b0;
    thermal_level = 16'h0000;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_definite();
    t_speed();
    t_i2t();
    t_stall();
    t_auto();
    print_verdict();
  end
endmodule : tb_motor_start_stall_supervisor
